// file: design/irsd_top.sv
// Input format routing, two-wire register port and short-to-battery sensing
// Contract
// - Format code picks core mode and routing
// - Single-ended composite powers down unused inputs
// - Codes 0-3 composite inputs 1-4, variant dependent
// - Codes 6,7 composite inputs 3,4 or 5,6
// - Luma/chroma codes route input pairs per variant
// - Code 0C component on inputs 1,2,3, six-input variant only
// - Differential codes pair inputs per variant
// - Sense above threshold is short event
// - Short event raises interrupt request pin
// - Readback shows which sense pin tripped
// - Sensing disabled after reset
// - Sense one power-down bit, resets 1
// - Sense one threshold eight levels, default 3
// - Sense two power-down bit, resets 1
// - Sense two threshold same coding, default 3
`timescale 1ns/1ps
module irsd_top #(
	parameter logic P_SIX_INPUT = 1'b1
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_alsb,
	input  wire logic                 i_scl,
	input  wire logic                 i_sda,
	output logic                      o_sda,
	output logic                      o_sda_oe,
	input  wire logic [1:0]           i_sense_above,
	output logic      [1:0]           o_sense_power_down,
	output logic      [2:0]           o_sense1_threshold,
	output logic      [2:0]           o_sense2_threshold,
	output irsd_pkg::irsd_mode_e      o_core_mode,
	output logic      [2:0]           o_route_a,
	output logic      [2:0]           o_route_b,
	output logic      [2:0]           o_route_c,
	output logic      [5:0]           o_ain_power_up,
	output logic                      o_interrupt_request_pin
);
	import irsd_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [4:0] fmt,
		input logic [1:0] pd, input logic [1:0][2:0] thr, input logic [1:0] flags);
		logic [7:0] r;
		r = 8'h00;
		case (addr)
			ADDR_FORMAT: r[FMT_MSB:0] = fmt;
			ADDR_SENSE1: begin
				r[PD_BIT]          = pd[0];
				r[THR_MSB:THR_LSB] = thr[0];
			end
			ADDR_SENSE2: begin
				r[PD_BIT]          = pd[1];
				r[THR_MSB:THR_LSB] = thr[1];
			end
			ADDR_STATUS: r[1:0] = flags;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	function automatic logic [5:0] ain_bit(input logic [2:0] idx);
		logic [5:0] b;
		b = 6'h00;
		if (idx != 3'h0) begin
			b = 6'h01 << (idx - 3'h1);
		end
		return b;
	endfunction

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	irsd_i2c_e        state_ff, nxt_state;
	logic             scl_ff, sda_ff, nxt_scl, nxt_sda;
	logic [3:0]       cnt_ff, nxt_cnt;
	logic [7:0]       shift_ff, nxt_shift, sub_ff, nxt_sub, rdata_ff, nxt_rdata, rd_next;
	logic             rw_ff, nxt_rw, drv_ff, nxt_drv, nack_ff, nxt_nack;
	logic             scl_rise, scl_fall, start_cond, stop_cond, wr_stb;
	logic [4:0]       fmt_ff, nxt_fmt;
	logic [1:0]       pd_ff, nxt_pd, clr, flags;
	logic [1:0][2:0]  thr_ff, nxt_thr;
	logic             irq_ff, nxt_irq;
	irsd_mode_e       mode_ff, nxt_mode;
	logic [2:0]       ra_ff, rb_ff, rc_ff, nxt_ra, nxt_rb, nxt_rc;
	logic [5:0]       pu_ff, nxt_pu;

	assign scl_rise   = i_scl & ~scl_ff;
	assign scl_fall   = ~i_scl & scl_ff;
	assign start_cond = scl_ff & i_scl & sda_ff & ~i_sda;
	assign stop_cond  = scl_ff & i_scl & ~sda_ff & i_sda;
	assign rd_next    = reg_read(sub_ff + 8'h01, fmt_ff, pd_ff, thr_ff, flags);

	// ------------------------------------------------------------
	// Two-wire register port
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_scl   = i_scl;
		nxt_sda   = i_sda;
		nxt_cnt   = cnt_ff;
		nxt_shift = shift_ff;
		nxt_sub   = sub_ff;
		nxt_rw    = rw_ff;
		nxt_drv   = drv_ff;
		nxt_rdata = rdata_ff;
		nxt_nack  = nack_ff;
		wr_stb    = 1'b0;
		case (state_ff)
			ST_ADDR, ST_SUB, ST_WRITE: begin
				if (scl_rise) begin
					nxt_shift = {shift_ff[6:0], i_sda};
					nxt_cnt   = cnt_ff + 4'h1;
				end else if (scl_fall && cnt_ff == BYTE_BITS) begin
					nxt_cnt = 4'h0;
					if (state_ff == ST_ADDR) begin
						if (shift_ff[7:1] == {DEV_ADDR_HI, i_alsb}) begin
							nxt_drv   = 1'b1;
							nxt_rw    = shift_ff[0];
							nxt_state = ST_AACK;
						end else begin
							nxt_state = ST_IDLE;
						end
					end else if (state_ff == ST_SUB) begin
						nxt_sub   = shift_ff;
						nxt_drv   = 1'b1;
						nxt_state = ST_SACK;
					end else begin
						wr_stb    = 1'b1;
						nxt_drv   = 1'b1;
						nxt_state = ST_WACK;
					end
				end
			end
			ST_AACK, ST_SACK, ST_WACK: begin
				if (scl_fall) begin
					nxt_drv   = 1'b0;
					nxt_state = ST_WRITE;
					if (state_ff == ST_AACK && rw_ff) begin
						nxt_rdata = reg_read(sub_ff, fmt_ff, pd_ff, thr_ff, flags);
						nxt_drv   = ~nxt_rdata[7];
						nxt_state = ST_READ;
					end else if (state_ff == ST_AACK) begin
						nxt_state = ST_SUB;
					end else if (state_ff == ST_WACK) begin
						nxt_sub = sub_ff + 8'h01;
					end
				end
			end
			ST_READ: begin
				if (scl_rise) begin
					nxt_cnt = cnt_ff + 4'h1;
				end else if (scl_fall && cnt_ff == BYTE_BITS) begin
					nxt_cnt   = 4'h0;
					nxt_drv   = 1'b0;
					nxt_state = ST_RACK;
				end else if (scl_fall) begin
					nxt_rdata = {rdata_ff[6:0], 1'b0};
					nxt_drv   = ~rdata_ff[6];
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					nxt_nack = i_sda;
				end else if (scl_fall && nack_ff) begin
					nxt_state = ST_IDLE;
				end else if (scl_fall) begin
					nxt_sub   = sub_ff + 8'h01;
					nxt_rdata = rd_next;
					nxt_drv   = ~rd_next[7];
					nxt_state = ST_READ;
				end
			end
			ST_IDLE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
		if (start_cond) begin
			nxt_state = ST_ADDR;
			nxt_cnt   = 4'h0;
			nxt_drv   = 1'b0;
		end else if (stop_cond) begin
			nxt_state = ST_IDLE;
			nxt_drv   = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
			scl_ff   <= 1'b1;
			sda_ff   <= 1'b1;
			cnt_ff   <= 4'h0;
			shift_ff <= 8'h00;
			sub_ff   <= 8'h00;
			rw_ff    <= 1'b0;
			drv_ff   <= 1'b0;
			rdata_ff <= 8'h00;
			nack_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			scl_ff   <= nxt_scl;
			sda_ff   <= nxt_sda;
			cnt_ff   <= nxt_cnt;
			shift_ff <= nxt_shift;
			sub_ff   <= nxt_sub;
			rw_ff    <= nxt_rw;
			drv_ff   <= nxt_drv;
			rdata_ff <= nxt_rdata;
			nack_ff  <= nxt_nack;
		end
	end

	assign o_sda    = 1'b0;
	assign o_sda_oe = drv_ff;

	// ------------------------------------------------------------
	// Register file and interrupt
	// ------------------------------------------------------------
	always_comb begin
		nxt_fmt = fmt_ff;
		nxt_pd  = pd_ff;
		nxt_thr = thr_ff;
		clr     = 2'b00;
		nxt_irq = |flags;
		if (wr_stb) begin
			case (sub_ff)
				ADDR_FORMAT: nxt_fmt = shift_ff[FMT_MSB:0];
				ADDR_SENSE1: begin
					nxt_pd[0]  = shift_ff[PD_BIT];
					nxt_thr[0] = shift_ff[THR_MSB:THR_LSB];
				end
				ADDR_SENSE2: begin
					nxt_pd[1]  = shift_ff[PD_BIT];
					nxt_thr[1] = shift_ff[THR_MSB:THR_LSB];
				end
				ADDR_STATUS: clr = shift_ff[1:0];
				default: clr = 2'b00;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			fmt_ff <= RST_FMT;
			pd_ff  <= {RST_PD, RST_PD};
			thr_ff <= {RST_THR, RST_THR};
			irq_ff <= 1'b0;
		end else begin
			fmt_ff <= nxt_fmt;
			pd_ff  <= nxt_pd;
			thr_ff <= nxt_thr;
			irq_ff <= nxt_irq;
		end
	end

	assign o_sense_power_down      = pd_ff;
	assign o_sense1_threshold      = thr_ff[0];
	assign o_sense2_threshold      = thr_ff[1];
	assign o_interrupt_request_pin = irq_ff;

	// ------------------------------------------------------------
	// Sense channels
	// ------------------------------------------------------------
	irsd_sense_if sense_bus [2] ();

	for (genvar g = 0; g < 2; g++) begin : g_sense
		assign sense_bus[g].power_down = pd_ff[g];
		assign sense_bus[g].clear      = clr[g];
		assign flags[g]                = sense_bus[g].flag;
		irsd_sense_chan u_chan (
			.i_clock (i_clock),
			.i_rst_n (i_rst_n),
			.i_above (i_sense_above[g]),
			.bus     (sense_bus[g])
		);
	end

	// ------------------------------------------------------------
	// Format decode and routing
	// ------------------------------------------------------------
	always_comb begin
		nxt_mode = MODE_OFF;
		nxt_ra   = 3'h0;
		nxt_rb   = 3'h0;
		nxt_rc   = 3'h0;
		case (fmt_ff)
			FMT_CVBS_A: {nxt_mode, nxt_ra} = {MODE_CVBS, 3'h1};
			FMT_CVBS_B: {nxt_mode, nxt_ra} = {MODE_CVBS, 3'h2};
			FMT_CVBS_C: if (P_SIX_INPUT) {nxt_mode, nxt_ra} = {MODE_CVBS, 3'h3};
			FMT_CVBS_D: if (P_SIX_INPUT) {nxt_mode, nxt_ra} = {MODE_CVBS, 3'h4};
			FMT_CVBS_E: {nxt_mode, nxt_ra} = {MODE_CVBS, P_SIX_INPUT ? 3'h5 : 3'h3};
			FMT_CVBS_F: {nxt_mode, nxt_ra} = {MODE_CVBS, P_SIX_INPUT ? 3'h6 : 3'h4};
			FMT_YC_A: {nxt_mode, nxt_ra, nxt_rb} = {MODE_YC, 3'h1, 3'h2};
			FMT_YC_B: if (P_SIX_INPUT) {nxt_mode, nxt_ra, nxt_rb} = {MODE_YC, 3'h3, 3'h4};
			FMT_YC_C: begin
				nxt_mode = MODE_YC;
				nxt_ra   = P_SIX_INPUT ? 3'h5 : 3'h3;
				nxt_rb   = P_SIX_INPUT ? 3'h6 : 3'h4;
			end
			FMT_YPBPR: if (P_SIX_INPUT) begin
				{nxt_mode, nxt_ra, nxt_rb, nxt_rc} = {MODE_YPBPR, 3'h1, 3'h2, 3'h3};
			end
			FMT_DIFF_A: {nxt_mode, nxt_ra, nxt_rb} = {MODE_DIFF, 3'h1, 3'h2};
			FMT_DIFF_B: if (P_SIX_INPUT) {nxt_mode, nxt_ra, nxt_rb} = {MODE_DIFF, 3'h3, 3'h4};
			FMT_DIFF_C: begin
				nxt_mode = MODE_DIFF;
				nxt_ra   = P_SIX_INPUT ? 3'h5 : 3'h3;
				nxt_rb   = P_SIX_INPUT ? 3'h6 : 3'h4;
			end
			default: nxt_mode = MODE_OFF;
		endcase
		nxt_pu = ain_bit(nxt_ra) | ain_bit(nxt_rb) | ain_bit(nxt_rc);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			mode_ff <= MODE_OFF;
			ra_ff   <= 3'h0;
			rb_ff   <= 3'h0;
			rc_ff   <= 3'h0;
			pu_ff   <= 6'h00;
		end else begin
			mode_ff <= nxt_mode;
			ra_ff   <= nxt_ra;
			rb_ff   <= nxt_rb;
			rc_ff   <= nxt_rc;
			pu_ff   <= nxt_pu;
		end
	end

	assign o_core_mode    = mode_ff;
	assign o_route_a      = ra_ff;
	assign o_route_b      = rb_ff;
	assign o_route_c      = rc_ff;
	assign o_ain_power_up = pu_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	diff_mode_a: assert property (fmt_ff == FMT_DIFF_A |=> o_core_mode == MODE_DIFF)
		else $error("differential code not decoded");
	cvbs_power_a: assert property (o_core_mode == MODE_CVBS |-> $onehot(o_ain_power_up))
		else $error("unused input left powered");
	cvbs_low_a: assert property (fmt_ff == FMT_CVBS_D |=>
		o_route_a == (P_SIX_INPUT ? 3'h4 : 3'h0))
		else $error("code 3 routing wrong");
	cvbs_high_a: assert property (fmt_ff == FMT_CVBS_F |=>
		o_route_a == (P_SIX_INPUT ? 3'h6 : 3'h4))
		else $error("code 7 routing wrong");
	yc_route_a: assert property (fmt_ff == FMT_YC_C |=> o_core_mode == MODE_YC &&
		o_route_b == (P_SIX_INPUT ? 3'h6 : 3'h4))
		else $error("luma chroma routing wrong");
	comp_route_a: assert property (fmt_ff == FMT_YPBPR |=>
		(P_SIX_INPUT ? (o_route_c == 3'h3 && o_ain_power_up == 6'h07) : o_core_mode == MODE_OFF))
		else $error("component routing wrong");
	diff_pair_a: assert property (fmt_ff == FMT_DIFF_B |=>
		(P_SIX_INPUT ? o_route_a == 3'h3 : o_ain_power_up == 6'h00))
		else $error("differential pair wrong");
	sense_trip_a: assert property (i_sense_above[0] && !pd_ff[0] ##2 !pd_ff[0] |=> flags[0])
		else $error("short event not latched");
	irq_follow_a: assert property (o_interrupt_request_pin == ($past(flags) != 2'b00))
		else $error("interrupt does not follow flags");
	status_read_a: assert property (state_ff == ST_AACK && scl_fall && rw_ff &&
		sub_ff == ADDR_STATUS && !start_cond && !stop_cond |=> rdata_ff == {6'h00, $past(flags)})
		else $error("readback does not show flags");
	rst_value_a: assert property ($rose(i_rst_n) |-> pd_ff == 2'b11 &&
		thr_ff[0] == RST_THR && thr_ff[1] == RST_THR && flags == 2'b00)
		else $error("reset values wrong");
	thr_write_a: assert property (wr_stb && sub_ff == ADDR_SENSE2 |=>
		o_sense2_threshold == $past(shift_ff[THR_MSB:THR_LSB]) && pd_ff[1] == $past(shift_ff[PD_BIT]))
		else $error("sense two write lost");
	pd_write_a: assert property (wr_stb && sub_ff == ADDR_SENSE1 |=>
		o_sense_power_down[0] == $past(shift_ff[PD_BIT]) &&
		thr_ff[0] == $past(shift_ff[THR_MSB:THR_LSB]))
		else $error("sense one write lost");

	diff_seen_c: cover property (o_core_mode == MODE_DIFF);
	trip_seen_c: cover property ($rose(o_interrupt_request_pin));
	read_seen_c: cover property (state_ff == ST_RACK && scl_fall && !nack_ff);
	clear_seen_c: cover property (flags[1] ##1 !flags[1]);
endmodule

// file: design/irsd_pkg.sv
// Constants and types for input routing and short-to-battery sensing
package irsd_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_FORMAT = 8'h00;
	localparam logic [7:0] ADDR_SENSE1 = 8'h5D;
	localparam logic [7:0] ADDR_SENSE2 = 8'h5E;
	localparam logic [7:0] ADDR_STATUS = 8'h5F;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FMT_MSB = 4;
	localparam int PD_BIT  = 6;
	localparam int THR_MSB = 4;
	localparam int THR_LSB = 2;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [4:0] RST_FMT = 5'h00;
	localparam logic       RST_PD  = 1'b1;
	localparam logic [2:0] RST_THR = 3'h3;
	// ------------------------------------------------------------
	// Two-wire port
	// ------------------------------------------------------------
	localparam logic [5:0] DEV_ADDR_HI = 6'h10;
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	// ------------------------------------------------------------
	// Format codes
	// ------------------------------------------------------------
	localparam logic [4:0] FMT_CVBS_A = 5'h00;
	localparam logic [4:0] FMT_CVBS_B = 5'h01;
	localparam logic [4:0] FMT_CVBS_C = 5'h02;
	localparam logic [4:0] FMT_CVBS_D = 5'h03;
	localparam logic [4:0] FMT_CVBS_E = 5'h06;
	localparam logic [4:0] FMT_CVBS_F = 5'h07;
	localparam logic [4:0] FMT_YC_A   = 5'h08;
	localparam logic [4:0] FMT_YC_B   = 5'h09;
	localparam logic [4:0] FMT_YC_C   = 5'h0B;
	localparam logic [4:0] FMT_YPBPR  = 5'h0C;
	localparam logic [4:0] FMT_DIFF_A = 5'h0E;
	localparam logic [4:0] FMT_DIFF_B = 5'h0F;
	localparam logic [4:0] FMT_DIFF_C = 5'h11;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {MODE_OFF, MODE_CVBS, MODE_DIFF, MODE_YC, MODE_YPBPR} irsd_mode_e;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_SUB, ST_SACK, ST_WRITE, ST_WACK, ST_READ, ST_RACK
	} irsd_i2c_e;
endpackage

// file: design/irsd_sense_if.sv
// Control and status between register file and one sense channel
`timescale 1ns/1ps
interface irsd_sense_if;
	logic power_down;
	logic clear;
	logic flag;
	modport ctrl (output power_down, output clear, input flag);
	modport chan (input power_down, input clear, output flag);
endinterface

// file: design/irsd_sense_chan.sv
// One short-to-battery sense channel: synchroniser and sticky flag
`timescale 1ns/1ps
module irsd_sense_chan (
	input  wire logic    i_clock,
	input  wire logic    i_rst_n,
	input  wire logic    i_above,
	irsd_sense_if.chan   bus
);
	import irsd_pkg::*;

	logic s1_ff, s2_ff, flag_ff;
	logic nxt_s1, nxt_s2, nxt_flag;

	// ------------------------------------------------------------
	// Synchroniser and latched event
	// ------------------------------------------------------------
	always_comb begin
		// Masked while powered down so stale slicer noise never reaches the flag
		nxt_s1   = i_above & ~bus.power_down;
		nxt_s2   = s1_ff;
		nxt_flag = (flag_ff & ~bus.clear) | (s2_ff & ~bus.power_down);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_ff   <= 1'b0;
			s2_ff   <= 1'b0;
			flag_ff <= 1'b0;
		end else begin
			s1_ff   <= nxt_s1;
			s2_ff   <= nxt_s2;
			flag_ff <= nxt_flag;
		end
	end

	assign bus.flag = flag_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	flag_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		flag_ff && !bus.clear |=> flag_ff)
		else $error("sense flag dropped without clear");
	pd_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		bus.power_down ##1 (!flag_ff && bus.power_down) |=> !flag_ff)
		else $error("sense flag set while powered down");
endmodule

// file: bench/irsd_sense_src.sv
// Divider networks and slicer comparators in front of the two sense pins
`timescale 1ns/1ps
module irsd_sense_src #(
	parameter int P_R4 = 3,
	parameter int P_R5 = 1
) (
	input  wire logic       i_clock,
	input  wire logic [1:0] i_power_down,
	input  wire logic [2:0] i_thr_one,
	input  wire logic [2:0] i_thr_two,
	input  var  int         i_conn1_mv,
	input  var  int         i_conn2_mv,
	output logic      [1:0] o_above
);
	logic wander = 1'b0;
	int   pin_mv [2];
	int   lvl_mv [2];
	always @(posedge i_clock) wander <= ~wander;
	always_comb begin
		pin_mv[0] = i_conn1_mv * P_R5 / (P_R4 + P_R5);
		pin_mv[1] = i_conn2_mv * P_R5 / (P_R4 + P_R5);
		lvl_mv[0] = 75 + 150 * int'(i_thr_one);
		lvl_mv[1] = 75 + 150 * int'(i_thr_two);
		for (int n = 0; n < 2; n++) begin
			// Powered-down slicer output wanders
			o_above[n] = i_power_down[n] ? wander ^ n[0] : pin_mv[n] > lvl_mv[n];
		end
	end
endmodule

// file: bench/test_input_routing_and_short_diag.sv
// Bench for input routing on both variants, short-to-battery sensing on the six-input variant only
`timescale 1ns/1ps
module test_input_routing_and_short_diag;
	import irsd_pkg::*;
	logic             clock = 1'b0;
	logic             rst_n = 1'b0;
	logic             scl   = 1'b1;
	logic             sda_m = 1'b1;
	logic       [1:0] oe, sdo;
	wire  logic       sda   = sda_m & (~oe[0] | sdo[0]) & (~oe[1] | sdo[1]);
	logic       [1:0] pd [2];
	logic       [2:0] thr1 [2], thr2 [2], ra [2], rb [2], rc [2];
	irsd_mode_e       mode [2];
	logic       [5:0] pu [2];
	logic       [1:0] irq;
	logic       [1:0] above;
	int               cmv1 = 0, cmv2 = 0;
	int               errors = 0, num_checks = 0;

	always #12.5 clock = ~clock;

	for (genvar g = 0; g < 2; g++) begin : g_dut
		irsd_top #(
			.P_SIX_INPUT(g == 0)
		) i_dut (
			.i_clock                 (clock),
			.i_rst_n                 (rst_n),
			.i_alsb                  (g == 1),
			.i_scl                   (scl),
			.i_sda                   (sda),
			.o_sda                   (sdo[g]),
			.o_sda_oe                (oe[g]),
			.i_sense_above           (above),
			.o_sense_power_down      (pd[g]),
			.o_sense1_threshold      (thr1[g]),
			.o_sense2_threshold      (thr2[g]),
			.o_core_mode             (mode[g]),
			.o_route_a               (ra[g]),
			.o_route_b               (rb[g]),
			.o_route_c               (rc[g]),
			.o_ain_power_up          (pu[g]),
			.o_interrupt_request_pin (irq[g])
		);
	end

	irsd_sense_src i_src (
		.i_clock      (clock),
		.i_power_down (pd[0]),
		.i_thr_one    (thr1[0]),
		.i_thr_two    (thr2[0]),
		.i_conn1_mv   (cmv1),
		.i_conn2_mv   (cmv2),
		.o_above      (above)
	);

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic put_bit(input logic b, output logic got);
		sda_m = b;
		ticks(3);
		scl = 1'b1;
		ticks(3);
		got = sda;
		ticks(1);
		scl = 1'b0;
		ticks(1);
	endtask

	task automatic start_cond;
		sda_m = 1'b1;
		ticks(3);
		scl = 1'b1;
		ticks(3);
		sda_m = 1'b0;
		ticks(3);
		scl = 1'b0;
		ticks(1);
	endtask

	task automatic stop_cond;
		sda_m = 1'b0;
		ticks(3);
		scl = 1'b1;
		ticks(3);
		sda_m = 1'b1;
		ticks(3);
	endtask

	// Ninth bit: master level out, wire level back
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
		put_bit(last, ack);
	endtask

	task automatic reg_wr(input logic dev, input logic [7:0] sub, input logic [7:0] val);
		logic [7:0] r;
		logic       a0, a1, a2;
		start_cond();
		xfer({DEV_ADDR_HI, dev, 1'b0}, 1'b1, r, a0);
		xfer(sub, 1'b1, r, a1);
		xfer(val, 1'b1, r, a2);
		stop_cond();
		check("write ack", {5'h00, a0, a1, a2}, 8'h00);
	endtask

	task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp, input string what);
		logic [7:0] r;
		logic [7:0] val;
		logic       a0, a1, a2, nak;
		start_cond();
		xfer({DEV_ADDR_HI, 2'h0}, 1'b1, r, a0);
		xfer(sub, 1'b1, r, a1);
		start_cond();
		xfer({DEV_ADDR_HI, 2'h1}, 1'b1, r, a2);
		xfer(8'hFF, 1'b1, val, nak);
		stop_cond();
		check("read ack", {5'h00, a0, a1, a2}, 8'h00);
		check(what, val, exp);
	endtask

	function automatic void exp_fmt(input logic [4:0] k, input logic six, output logic [2:0] m,
			output logic [2:0] a, output logic [2:0] b, output logic [2:0] c);
		logic [2:0] o;
		o = six ? 3'h2 : 3'h0;
		{m, a, b, c} = {MODE_OFF, 9'h000};
		case (k)
			5'h00, 5'h01: {m, a} = {MODE_CVBS, k[2:0] + 3'h1};
			5'h02, 5'h03: if (six) {m, a} = {MODE_CVBS, k[2:0] + 3'h1};
			5'h06, 5'h07: {m, a} = {MODE_CVBS, k[2:0] - 3'h3 + o};
			5'h08: {m, a, b} = {MODE_YC, 3'h1, 3'h2};
			5'h09: if (six) {m, a, b} = {MODE_YC, 3'h3, 3'h4};
			5'h0B: {m, a, b} = {MODE_YC, 3'h3 + o, 3'h4 + o};
			5'h0C: if (six) {m, a, b, c} = {MODE_YPBPR, 3'h1, 3'h2, 3'h3};
			5'h0E: {m, a, b} = {MODE_DIFF, 3'h1, 3'h2};
			5'h0F: if (six) {m, a, b} = {MODE_DIFF, 3'h3, 3'h4};
			5'h11: {m, a, b} = {MODE_DIFF, 3'h3 + o, 3'h4 + o};
			default: ;
		endcase
	endfunction

	task automatic t_reset;
		logic [7:0] r;
		logic       a;
		check("pd", {6'h00, pd[0]}, 8'h03);
		check("thr1", {5'h00, thr1[0]}, 8'h03);
		check("thr2", {5'h00, thr2[0]}, 8'h03);
		check("irq", {6'h00, irq}, 8'h00);
		rd_chk(ADDR_SENSE1, 8'h4C, "sense1 reg");
		rd_chk(ADDR_SENSE2, 8'h4C, "sense2 reg");
		rd_chk(ADDR_STATUS, 8'h00, "status");
		rd_chk(8'h10, 8'h00, "unmapped");
		start_cond();
		xfer(8'h44, 1'b1, r, a);
		stop_cond();
		check("foreign address", {7'h00, a}, 8'h01);
	endtask

	task automatic t_formats;
		logic [2:0] m, a, b, c;
		logic [5:0] p;
		for (int k = 0; k < 32; k++) begin
			if (k[4:0] inside {5'h04, 5'h05, 5'h0A, 5'h0D, 5'h10} || k[4:0] >= 5'h12) continue;
			for (int v = 0; v < 2; v++) begin
				reg_wr(v[0], ADDR_FORMAT, {3'h7, k[4:0]});
				ticks(1);
				exp_fmt(k[4:0], v == 0, m, a, b, c);
				p = 6'(((7'h01 << a) | (7'h01 << b) | (7'h01 << c)) >> 1);
				check("mode", {5'h00, mode[v]}, {5'h00, m});
				check("route a", {5'h00, ra[v]}, {5'h00, a});
				check("route b", {5'h00, rb[v]}, {5'h00, b});
				check("route c", {5'h00, rc[v]}, {5'h00, c});
				check("power up", {2'h0, pu[v]}, {2'h0, p});
			end
			rd_chk(ADDR_FORMAT, {3'h0, k[4:0]}, "format reg");
		end
	endtask

	task automatic t_sense;
		cmv1 = 4000;
		ticks(8);
		check("irq off", {7'h00, irq[0]}, 8'h00);
		rd_chk(ADDR_STATUS, 8'h00, "status off");
		cmv1 = 0;
		reg_wr(1'b0, ADDR_SENSE1, 8'h0C);
		reg_wr(1'b0, ADDR_SENSE1, 8'h14);
		check("pd one up", {6'h00, pd[0]}, 8'h02);
		check("thr1 set", {5'h00, thr1[0]}, 8'h05);
		cmv1 = 3300;
		ticks(8);
		check("irq at level", {7'h00, irq[0]}, 8'h00);
		cmv1 = 3400;
		ticks(1);
		cmv1 = 0;
		ticks(2);
		check("irq early", {7'h00, irq[0]}, 8'h00);
		ticks(1);
		check("irq", {7'h00, irq[0]}, 8'h01);
		rd_chk(ADDR_STATUS, 8'h01, "status one");
		check("irq held", {7'h00, irq[0]}, 8'h01);
		reg_wr(1'b0, ADDR_STATUS, 8'h01);
		check("irq cleared", {7'h00, irq[0]}, 8'h00);
		reg_wr(1'b0, ADDR_SENSE2, 8'h0C);
		reg_wr(1'b0, ADDR_SENSE2, 8'h00);
		check("pd both up", {6'h00, pd[0]}, 8'h00);
		check("thr2 set", {5'h00, thr2[0]}, 8'h00);
		cmv2 = 400;
		ticks(8);
		check("irq two", {7'h00, irq[0]}, 8'h01);
		cmv2 = 0;
		rd_chk(ADDR_STATUS, 8'h02, "status two");
		reg_wr(1'b0, ADDR_STATUS, 8'h02);
		rd_chk(ADDR_STATUS, 8'h00, "status clear");
		check("irq idle", {6'h00, irq}, 8'h00);
	endtask

	initial begin
		ticks(3);
		rst_n = 1'b1;
		ticks(2);
		t_reset();
		t_formats();
		t_sense();
		give_verdict();
	end

	initial begin
		#(60000 * 25);
		errors++;
		give_verdict();
	end
endmodule
